// ==== verilog/nvp_pkg.sv ====
package nvp_pkg;
   // memory layout
   localparam int          NVP_PAGES      = 32;
   localparam int          NVP_PAGE_BYTES = 16;
   localparam int          NVP_IDX_W      = 9;
   localparam logic [2:0]  BLK_REG        = 3'h0;
   localparam logic [2:0]  BLK_CFG        = 3'h2;
   localparam logic [2:0]  BLK_EEP        = 3'h3;
   localparam logic [3:0]  PROT_PAGE      = 4'hE;
   localparam logic [3:0]  SVC_PAGE       = 4'hF;
   // protection settings held in the protection page
   localparam logic [7:0]  PROT_REG_ADDR  = 8'hE2;
   localparam logic [7:0]  LOCK_ADDR      = 8'hE4;
   localparam int          LOCK_BIT_POS   = 0;
   localparam int          SEC_BIT        = 1;
   localparam int          PROT_EN_POS    = 2;
   localparam logic [2:0]  PROT_REG_RST   = 3'h0;
   // erase timing
   localparam int          T_ER_US        = 20000;
   localparam int          CLK_PERIOD_PS  = 5000;
   // scaled per microsecond first so the product stays inside 32 bits
   localparam int          ERASE_CYCLES   = T_ER_US * (1000000 / CLK_PERIOD_PS);
   localparam int          FIFO_DEPTH     = 32;

   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_READ  = 2'h1,
      OP_ERASE = 2'h2,
      OP_SRST  = 2'h3
   } nvp_op_type;

   typedef struct packed {
      nvp_op_type  op;
      logic [2:0]  blk;
      logic [7:0]  addr;
      logic [7:0]  data;
   } nvp_cmd_type;

   typedef struct packed {
      logic        valid;
      logic [7:0]  data;
   } nvp_rsp_type;
endpackage

// ==== verilog/nvp_top.sv ====
`timescale 1ns/100ps

module nvp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   // filling side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // draining side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          in_rdy;
      logic          out_vld;
   } nvp_fifo_st_type;

   nvp_fifo_st_type s_q, s_d;
   logic [W-1:0]    buf_mem [0:DEPTH-1];
   logic            push, pop;

   assign push      = in_valid && s_q.in_rdy;
   assign pop       = s_q.out_vld && out_ready;
   assign in_ready  = s_q.in_rdy;
   assign out_valid = s_q.out_vld;
   assign out_data  = buf_mem[s_q.rp];

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.wp = AW'(s_q.wp + 1'b1);
      end
      if (pop) begin
         s_d.rp = AW'(s_q.rp + 1'b1);
      end
      s_d.cnt     = (AW+1)'(s_q.cnt + {AW'(0), push} - {AW'(0), pop});
      // flags registered so the ready seen outside comes from a flop
      s_d.in_rdy  = (s_d.cnt != (AW+1)'(DEPTH));
      s_d.out_vld = (s_d.cnt != '0);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '{wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1, out_vld: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         buf_mem[s_q.wp] <= in_data;
      end
   end
endmodule // nvp_fifo

module nvp_top import nvp_pkg::*; #(
   parameter int ERASE_CYC = ERASE_CYCLES
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // decoded bus commands
   input  wire logic        cmd_valid,
   input  wire nvp_cmd_type cmd,
   output logic             cmd_ready,
   // read answers
   output nvp_rsp_type      rsp,
   // status
   output logic             busy,
   output logic             refused,
   output logic [2:0]       prot_state,
   output logic             prot_locked
);
   localparam int CW = $clog2(ERASE_CYC + 1);

   typedef enum logic [2:0] {
      ST_LOAD  = 3'b001,
      ST_IDLE  = 3'b010,
      ST_ERASE = 3'b100
   } nvp_st_type;

   typedef struct packed {
      nvp_st_type  st;
      logic [2:0]  prot_reg;
      logic        prot_lk;
      logic        sec;
      logic [CW-1:0] cnt;
      logic [4:0]  epage;
      nvp_rsp_type rsp;
      logic        refused;
      logic        busy;
   } nvp_state_type;

   nvp_state_type  s_q, s_d;
   logic [7:0]     nvm [0:NVP_PAGES*NVP_PAGE_BYTES-1];
   logic           f_vld, f_rdy, pop;
   nvp_cmd_type    c;
   logic [NVP_IDX_W-1:0] idx;
   logic           mem_we, clr_en, in_mem, blk_prot, erase_prot;
   logic [7:0]     mem_wdata;

   nvp_fifo #(.W($bits(nvp_cmd_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (cmd_valid),
      .in_data   (cmd),
      .in_ready  (cmd_ready),
      .out_valid (f_vld),
      .out_data  (c),
      .out_ready (f_rdy)
   );

   // page protection for a 5-bit page number
   function automatic logic page_prot(input logic [4:0] p, input logic [2:0] w,
                                      input logic lk);
      logic r;
      if (p[4]) begin
         r = w[PROT_EN_POS] && (p[3:2] >= (2'd3 - w[1:0]));
      end else begin
         r = (p[3:0] == SVC_PAGE) || ((p[3:0] == PROT_PAGE) && lk);
      end
      return r;
   endfunction

   assign f_rdy      = (s_q.st == ST_IDLE);
   assign pop        = f_vld && f_rdy;
   assign in_mem     = (c.blk == BLK_CFG) || (c.blk == BLK_EEP);
   assign idx        = {c.blk == BLK_EEP, c.addr};
   // whole-page granularity: only the page number is checked
   assign blk_prot   = page_prot(idx[8:4], s_q.prot_reg, s_q.sec || s_q.prot_lk);
   assign erase_prot = page_prot(c.addr[4:0], s_q.prot_reg, s_q.sec || s_q.prot_lk);
   assign mem_wdata  = nvm[idx] | c.data;
   assign mem_we     = pop && (c.op == OP_WRITE) && in_mem && !blk_prot;
   assign clr_en     = (s_q.st == ST_ERASE) && (s_q.cnt == '0);

   always_comb begin
      s_d         = s_q;
      s_d.rsp     = '0;
      s_d.refused = 1'b0;
      case (s_q.st)
         ST_LOAD: begin
            // lock and sec come only from the stored page, so their changes wait for reset or an OP_SRST reload; prot_reg can also be written directly
            s_d.prot_reg = nvm[{1'b0, PROT_REG_ADDR}][2:0];
            s_d.prot_lk  = nvm[{1'b0, LOCK_ADDR}][LOCK_BIT_POS];
            s_d.sec = nvm[{1'b0, LOCK_ADDR}][SEC_BIT];
            s_d.st  = ST_IDLE;
         end
         ST_IDLE: begin
            if (pop) begin
               case (c.op)
                  OP_WRITE: begin
                     if (in_mem) begin
                        s_d.refused = blk_prot;
                     end else if ((c.blk == BLK_REG) && (c.addr == PROT_REG_ADDR)) begin
                        if (s_q.prot_lk) begin
                           s_d.refused = 1'b1;
                        end else begin
                           s_d.prot_reg = c.data[2:0];
                        end
                     end
                  end
                  OP_READ: begin
                     s_d.rsp.valid = 1'b1;
                     if (in_mem) begin
                        s_d.rsp.data = nvm[idx];
                     end else if ((c.blk == BLK_REG) && (c.addr == PROT_REG_ADDR)) begin
                        s_d.rsp.data = {5'h00, s_q.prot_reg};
                     end
                  end
                  OP_ERASE: begin
                     if (erase_prot) begin
                        s_d.refused = 1'b1;
                     end else begin
                        s_d.st    = ST_ERASE;
                        s_d.epage = c.addr[4:0];
                        s_d.cnt   = CW'(ERASE_CYC - 1);
                     end
                  end
                  OP_SRST: begin
                     s_d.st = ST_LOAD;
                  end
                  default: begin
                     s_d.st = ST_IDLE;
                  end
               endcase
            end
         end
         ST_ERASE: begin
            if (clr_en) begin
               s_d.st = ST_IDLE;
            end else begin
               s_d.cnt = CW'(s_q.cnt - 1'b1);
            end
         end
         default: begin
            s_d.st = ST_LOAD;
         end
      endcase
      s_d.busy = (s_d.st != ST_IDLE);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '{st:       ST_LOAD,
                  prot_reg: PROT_REG_RST,
                  prot_lk:  1'b0,
                  sec:      1'b0,
                  cnt:      '0,
                  epage:    '0,
                  rsp:      '0,
                  refused:  1'b0,
                  busy:     1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   // nonvolatile array: no reset, erased state is all zero
   always_ff @(posedge mclk) begin
      if (clr_en) begin
         for (int i = 0; i < NVP_PAGE_BYTES; i++) begin
            nvm[{s_q.epage, 4'(i)}] <= 8'h00;
         end
      end else if (mem_we) begin
         nvm[idx] <= mem_wdata;
      end
   end

   assign rsp         = s_q.rsp;
   assign busy        = s_q.busy;
   assign refused     = s_q.refused;
   assign prot_state  = s_q.prot_reg;
   assign prot_locked = s_q.prot_lk;

   // helpers for the checks below
   logic [NVP_IDX_W-1:0] chk_idx_q;
   logic [7:0]           chk_old_q;
   always_ff @(posedge mclk) begin
      chk_idx_q <= idx;
      chk_old_q <= nvm[idx];
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   svc_page_a: assert property (mem_we |-> idx[8:4] != 5'h0F)
      else $error("service page written");
   sec_page_a: assert property (s_q.sec && mem_we |-> idx[8:4] != 5'h0E)
      else $error("locked protection page written");
   reg_freeze_a: assert property (s_q.prot_lk && s_q.st == ST_IDLE |=> $stable(s_q.prot_reg))
      else $error("locked protect register changed");
   eep_open_a: assert property (pop && c.op == OP_WRITE && c.blk == BLK_EEP
                                && !s_q.prot_reg[2] |-> mem_we)
      else $error("unprotected eeprom write dropped");
   quarter_prot_a: assert property (s_q.prot_reg == 3'b100 && mem_we && idx[8]
                                    |-> idx[7:6] != 2'b11)
      else $error("upper quarter written while protected");
   all_prot_a: assert property (s_q.prot_reg == 3'b111 |-> !(mem_we && idx[8]))
      else $error("eeprom written while fully protected");
   no_clear_a: assert property (mem_we |=> (nvm[chk_idx_q] & chk_old_q) == chk_old_q)
      else $error("program cleared a stored bit");
   // the load right after reset reads an array that may still be blank
   reload_a: assert property (s_q.st == ST_LOAD && $past(s_q.st) == ST_IDLE
                              |=> s_q.prot_reg == $past(nvm[{1'b0, PROT_REG_ADDR}][2:0]))
      else $error("protect register not loaded from page");

   // block field, lock, load, erase and read answer checks
   half_prot_a: assert property (s_q.prot_reg == 3'b101 && mem_we && idx[8]
                                 |-> !idx[7])
      else $error("upper half written while protected");
   three_q_prot_a: assert property (s_q.prot_reg == 3'b110 && mem_we && idx[8]
                                    |-> idx[7:6] == 2'b00)
      else $error("upper three quarters written while protected");
   prot_off_a: assert property (pop && c.op == OP_WRITE && c.blk == BLK_EEP
                                && !s_q.prot_reg[2]
                                |=> !refused)
      else $error("write refused with protection off");
   lock_refuse_a: assert property (pop && c.op == OP_WRITE && c.blk == BLK_REG
                                   && c.addr == PROT_REG_ADDR && s_q.prot_lk
                                   |=> refused)
      else $error("locked protect register write not refused");
   reg_write_a: assert property (pop && c.op == OP_WRITE && c.blk == BLK_REG
                                 && c.addr == PROT_REG_ADDR && !s_q.prot_lk
                                 |=> s_q.prot_reg == $past(c.data[2:0]))
      else $error("protect register write lost");
   load_done_a: assert property (s_q.st == ST_LOAD
                                 |=> s_q.st == ST_IDLE)
      else $error("settings load did not finish");
   page_clear_a: assert property (clr_en |=> nvm[{s_q.epage, 4'h0}] == 8'h00
                                  && nvm[{s_q.epage, 4'hF}] == 8'h00)
      else $error("erased page not cleared");
   svc_erase_a: assert property (pop && c.op == OP_ERASE && c.addr[4:0] == 5'h0F
                                 |=> refused)
      else $error("service page erase not refused");
   sec_erase_a: assert property (pop && c.op == OP_ERASE && c.addr[4:0] == 5'h0E
                                 && s_q.sec |=> refused)
      else $error("secured protection page erase not refused");
   erase_busy_a: assert property (pop && c.op == OP_ERASE && !erase_prot
                                  |=> busy)
      else $error("open page erase not started");
   read_ans_a: assert property (pop && c.op == OP_READ |=> rsp.valid ##1 !rsp.valid)
      else $error("read answer missing or stretched");
   erase_prot_a: assert property (pop && c.op == OP_ERASE && erase_prot
                                  |=> refused && s_q.st == ST_IDLE)
      else $error("protected page erase not refused");

   erase_done_c: cover property (clr_en);
   refused_c:    cover property (refused);
   wpr_read_c:   cover property (pop && c.op == OP_READ && c.blk == BLK_REG);
   fifo_full_c:  cover property (!cmd_ready);
   lock_live_c:  cover property (s_q.prot_lk && refused);
endmodule // nvp_top

// ==== test/nvp_ctl_model.sv ====
`timescale 1ns/100ps

// decoded-command stand-in for the bus controller
module nvp_ctl_model import nvp_pkg::*; (
   // clock
   input  wire logic        mclk,
   // command port
   input  wire logic        cmd_ready,
   output logic             cmd_valid,
   output nvp_cmd_type      cmd
);
   initial begin
      cmd_valid = 1'b0;
      cmd       = '0;
   end

   // held until taken; released word shows the inverse, not a stale copy
   task automatic send(input nvp_op_type op, input logic [2:0] blk, input logic [7:0] addr,
                       input logic [7:0] data);
      @(posedge mclk);
      #1;
      cmd_valid = 1'b1;
      cmd       = '{op: op, blk: blk, addr: addr, data: data};
      while (cmd_ready !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      cmd       = nvp_cmd_type'(~cmd);
   endtask
endmodule // nvp_ctl_model

// ==== test/tb.sv ====
`timescale 1ns/100ps

module tb import nvp_pkg::*; ;
   logic        mclk;
   logic        sys_rst;
   logic        cmd_valid;
   nvp_cmd_type cmd;
   logic        cmd_ready;
   nvp_rsp_type rsp;
   logic        busy;
   logic        refused;
   logic [2:0]  prot_state;
   logic        prot_locked;
   logic        ref_seen;
   logic [7:0]  rd_q;
   int          fail_count;
   int          check_count;
   int          cyc;

   nvp_top #(.ERASE_CYC(8)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp), .busy(busy), .refused(refused),
      .prot_state(prot_state), .prot_locked(prot_locked));
   nvp_ctl_model ctl_u (.mclk(mclk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd));

   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   // pulses last one cycle, so latch them
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (refused === 1'b1) ref_seen <= 1'b1;
      if (rsp.valid === 1'b1) rd_q <= rsp.data;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one command, then wait out the engine under a bound
   task automatic run(input nvp_op_type op, input logic [2:0] blk, input logic [7:0] addr,
                      input logic [7:0] data);
      int n;
      ref_seen = 1'b0;
      ctl_u.send(op, blk, addr, data);
      repeat (3) @(posedge mclk);
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      #1;
   endtask

   task automatic t_init();
      run(OP_ERASE, BLK_CFG, 8'h0E, 8'h00);
      run(OP_SRST, BLK_REG, 8'h00, 8'h00);
      check("prot_state", {6'h0, prot_state}, 9'h000);
      check("prot_locked", {8'h0, prot_locked}, 9'h000);
      run(OP_ERASE, BLK_CFG, 8'h0F, 8'h00);
      check("svc_erase_ref", {8'h0, ref_seen}, 9'h001);
      // service page bytes are never compared against expected data
      run(OP_WRITE, BLK_CFG, 8'hF3, 8'h5A);
      check("svc_write_ref", {8'h0, ref_seen}, 9'h001);
      $display("test init done");
   endtask

   task automatic t_eep();
      run(OP_ERASE, BLK_CFG, 8'h10, 8'h00);
      for (int i = 0; i < NVP_PAGE_BYTES; i++) run(OP_WRITE, BLK_EEP, 8'(i), 8'(i + 'h30));
      for (int i = 0; i < NVP_PAGE_BYTES; i++) begin
         run(OP_READ, BLK_EEP, 8'(i), 8'h00);
         check("eep_rd", {1'b0, rd_q}, 9'(i + 'h30));
      end
      run(OP_WRITE, BLK_EEP, 8'h05, 8'hC0);
      run(OP_READ, BLK_EEP, 8'h05, 8'h00);
      check("or_prog", {1'b0, rd_q}, 9'h0F5);
      run(OP_ERASE, BLK_CFG, 8'h10, 8'h00);
      run(OP_READ, BLK_EEP, 8'h0F, 8'h00);
      check("erased", {1'b0, rd_q}, 9'h000);
      $display("test eeprom done");
   endtask

   task automatic t_prot();
      // every eeprom page erased so each byte is programmed from a blank state
      for (int p = 0; p < NVP_PAGES / 2; p++) run(OP_ERASE, BLK_CFG, 8'(16 + p), 8'h00);
      for (int b = 0; b < 4; b++) begin
         run(OP_WRITE, BLK_REG, PROT_REG_ADDR, 8'(4 + b));
         check("prot_state", {6'h0, prot_state}, 9'(4 + b));
         run(OP_READ, BLK_REG, PROT_REG_ADDR, 8'h00);
         check("prot_reg_rd", {1'b0, rd_q}, 9'(4 + b));
         run(OP_WRITE, BLK_EEP, 8'((12 - 4 * b) * 16), 8'h11);
         check("prot_ref", {8'h0, ref_seen}, 9'h001);
         if (b < 3) begin
            run(OP_WRITE, BLK_EEP, 8'((11 - 4 * b) * 16), 8'h00);
            check("free_ref", {8'h0, ref_seen}, 9'h000);
         end
      end
      run(OP_WRITE, BLK_EEP, 8'hF2, 8'hFF);
      run(OP_READ, BLK_EEP, 8'hF2, 8'h00);
      check("prot_keep", {1'b0, rd_q}, 9'h000);
      run(OP_WRITE, BLK_REG, PROT_REG_ADDR, 8'h00);
      run(OP_WRITE, BLK_EEP, 8'hF2, 8'h00);
      check("off_ref", {8'h0, ref_seen}, 9'h000);
      $display("test protect done");
   endtask

   task automatic t_lock();
      run(OP_WRITE, BLK_CFG, LOCK_ADDR, 8'h03);
      check("lock_early", {8'h0, prot_locked}, 9'h000);
      run(OP_SRST, BLK_REG, 8'h00, 8'h00);
      check("lock_live", {8'h0, prot_locked}, 9'h001);
      run(OP_WRITE, BLK_REG, PROT_REG_ADDR, 8'h07);
      check("reg_lk_ref", {8'h0, ref_seen}, 9'h001);
      check("reg_frozen", {6'h0, prot_state}, 9'h000);
      run(OP_WRITE, BLK_CFG, 8'hE0, 8'h01);
      check("pg14_ref", {8'h0, ref_seen}, 9'h001);
      $display("test lock done");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      sys_rst     = 1'b1;
      ref_seen    = 1'b0;
      rd_q        = 8'h00;
      fail_count  = 0;
      check_count = 0;
      cyc         = 0;
      repeat (2) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      t_init();
      t_eep();
      t_prot();
      t_lock();
      give_verdict();
   end
endmodule // tb
